// ---- hw/tpg_defs.vh ----
// Constants for the two-phase pulse generator: offsets, fields, codes, reset values
//
// Functional notes
// - Period and first-phase lengths are 32-bit counters, software programmable.
// - An 8-bit repeat value gives repeat plus one periods per one-shot run.
// - All counting advances on the single module reference clock.
// - While idle, before or after a run, the pin shows the idle level.
// - First phase shows first-phase level for first-phase length clocks; period sets total.
// - After the first phase the pin shows the inverse level until period end.
// - First-phase length zero gives the inverse level for the whole period.
// - First-phase length at least period plus one gives first-phase level throughout.
// - Mode code 1 selects one-shot operation bounded by the repeat count.
// - Writing 1 to start begins with the latest programmed settings.
// - One-shot ends after repeat plus one periods, interrupts if enabled, stays idle.
// - Writing mode 0 stops in any mode; pin goes to idle level at once.
// - Camera vsync trigger is synchronised; rising or falling edge detected as configured.
// - With triggering on, start only arms; counting begins at the first edge after.
// - Once a triggered run starts, further edges are ignored until next start write.
// - Mode code 2 selects continuous back-to-back periods; repeat count unused.
// - Continuous mode copies period and phase into shadows each period start, then interrupts.
// - Continuous to one-shot while running runs repeat plus one more periods, then stops.
// - DMA event pulses at the interrupt moments even while the interrupt-enable bit is clear.
// - Interrupts in both modes are gated by the interrupt-enable bit.
`ifndef TPG_DEFS_VH
`define TPG_DEFS_VH

// Register byte offsets
`define TPG_OFF_IDENT     12'h000
`define TPG_OFF_CONFIG    12'h008
`define TPG_OFF_START     12'h00C
`define TPG_OFF_REPEAT    12'h010
`define TPG_OFF_PERIOD    12'h014
`define TPG_OFF_PHASE     12'h018

// Configuration register fields
`define TPG_CFG_MODE_LSB  0
`define TPG_CFG_MODE_MSB  1
`define TPG_CFG_TRIG_LSB  2
`define TPG_CFG_TRIG_MSB  3
`define TPG_CFG_P1LEV     4
`define TPG_CFG_IDLELEV   5
`define TPG_CFG_IRQEN     6
`define TPG_CFG_CURLEV    16
`define TPG_CFG_RUNNING   17
`define TPG_START_BIT     0

// Mode and trigger codes
`define TPG_MODE_OFF      2'h0
`define TPG_MODE_ONESHOT  2'h1
`define TPG_MODE_CONT     2'h2
`define TPG_TRIG_OFF      2'h0
`define TPG_TRIG_RISE     2'h1
`define TPG_TRIG_FALL     2'h2

// Reset values
`define TPG_RST_CONFIG    7'h00
`define TPG_RST_REPEAT    8'h00
`define TPG_RST_PERIOD    32'h00000000
`define TPG_RST_PHASE     32'h00000000

// Clock period, for reference only; all lengths are given in clocks
`define TPG_CLK_PERIOD_NS 100

`endif

// ---- hw/tpg_top.v ----
// Two-phase pulse generator with APB register slave
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "tpg_defs.vh"

module tpg_top #(
   parameter        CNT_W    = 32,
   parameter        RPT_W    = 8,
   parameter [31:0] IDENT    = 32'h00A5A501 // Arbitrary identification value
) (
   input  wire        clock,
   input  wire        reset,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        camera_vsync_in,
   output reg         waveform_out,
   output reg         irq_out,
   output reg         dma_event_out
);

   // One-hot controller states
   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_ARMED = 3'h2;
   localparam [2:0] ST_RUN   = 3'h4;

   // Output level for a count position within the period
   function phase_level;
      input [CNT_W-1:0] pos;
      input [CNT_W-1:0] len;
      input             lev;
      begin
         phase_level = (pos < len) ? lev : ~lev;
      end
   endfunction

   // Software-visible settings
   reg  [1:0]       mode_ff;
   reg  [1:0]       trig_sel_ff;
   reg              first_phase_level_ff;
   reg              idle_level_ff;
   reg              irq_enable_ff;
   reg  [RPT_W-1:0] repeat_count_ff;
   reg  [CNT_W-1:0] period_ff;
   reg  [CNT_W-1:0] first_phase_length_ff;

   // Run state
   reg  [2:0]       state_ff;
   reg  [2:0]       nxt_state;
   reg  [CNT_W-1:0] cnt_ff;
   reg  [CNT_W-1:0] nxt_cnt;
   reg  [CNT_W-1:0] per_sh_ff;
   reg  [CNT_W-1:0] nxt_per_sh;
   reg  [CNT_W-1:0] ph1_sh_ff;
   reg  [CNT_W-1:0] nxt_ph1_sh;
   reg  [RPT_W:0]   rem_ff;
   reg  [RPT_W:0]   nxt_rem;
   reg  [1:0]       mode_prev_ff;
   reg              nxt_wave;
   reg              nxt_event;

   // Trigger synchroniser and edge history
   reg              vs_meta_ff;
   reg              vs_sync_ff;
   reg              vs_last_ff;
   wire             rise_seen;
   wire             fall_seen;
   reg              trig_hit;

   // Bus decode
   wire             access;
   wire             wr_commit;
   wire             rd_take;
   wire             wr_start;
   reg              addr_ok;
   reg  [31:0]      rd_word;

   // Controller decode
   wire             mode_off;
   wire             mode_oneshot;
   wire             mode_cont;
   wire             trig_enabled;
   wire             period_end;
   wire             leave_cont;

   // One wait state: pready rises in the second access cycle
   assign access    = psel & penable;
   assign wr_commit = access & pready & pwrite;
   assign rd_take   = access & ~pready & ~pwrite;
   assign wr_start  = wr_commit & (paddr == `TPG_OFF_START) & pwdata[`TPG_START_BIT];

   // Mode decode; code 3 runs like continuous but raises no events
   assign mode_off     = (mode_ff == `TPG_MODE_OFF);
   assign mode_oneshot = (mode_ff == `TPG_MODE_ONESHOT);
   assign mode_cont    = (mode_ff == `TPG_MODE_CONT);

   // Reserved trigger code starts at once, like an untriggered run
   assign trig_enabled = (trig_sel_ff == `TPG_TRIG_RISE) |
                         (trig_sel_ff == `TPG_TRIG_FALL);

   // Period of per+1 clocks ends when the count meets the shadow
   assign period_end   = (cnt_ff == per_sh_ff);

   // High for one cycle after software leaves continuous for one-shot
   assign leave_cont   = mode_oneshot & (mode_prev_ff == `TPG_MODE_CONT);

   // Address map check
   always @* begin
      case (paddr)
         `TPG_OFF_IDENT,
         `TPG_OFF_CONFIG,
         `TPG_OFF_START,
         `TPG_OFF_REPEAT,
         `TPG_OFF_PERIOD,
         `TPG_OFF_PHASE: addr_ok = 1'b1;
         default:        addr_ok = 1'b0;
      endcase
   end

   // Read data mux; start reads back as zero
   always @* begin
      rd_word = 32'h00000000;
      case (paddr)
         `TPG_OFF_IDENT: rd_word = IDENT;
         `TPG_OFF_CONFIG: begin
            rd_word[`TPG_CFG_MODE_MSB:`TPG_CFG_MODE_LSB] = mode_ff;
            rd_word[`TPG_CFG_TRIG_MSB:`TPG_CFG_TRIG_LSB] = trig_sel_ff;
            rd_word[`TPG_CFG_P1LEV]   = first_phase_level_ff;
            rd_word[`TPG_CFG_IDLELEV] = idle_level_ff;
            rd_word[`TPG_CFG_IRQEN]   = irq_enable_ff;
            rd_word[`TPG_CFG_CURLEV]  = waveform_out;
            rd_word[`TPG_CFG_RUNNING] = state_ff[2];
         end
         `TPG_OFF_REPEAT: rd_word[RPT_W-1:0] = repeat_count_ff;
         `TPG_OFF_PERIOD: rd_word[CNT_W-1:0] = period_ff;
         `TPG_OFF_PHASE:  rd_word[CNT_W-1:0] = first_phase_length_ff;
         default:         rd_word = 32'h00000000;
      endcase
   end

   // APB handshake and read capture
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= access & ~pready;
         pslverr <= access & ~pready & ~addr_ok;
         if (rd_take) begin
            prdata <= rd_word;
         end
      end
   end

   // Register writes take effect at the completing edge only
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         mode_ff               <= `TPG_MODE_OFF;
         trig_sel_ff           <= `TPG_TRIG_OFF;
         first_phase_level_ff  <= 1'b0;
         idle_level_ff         <= 1'b0;
         irq_enable_ff         <= 1'b0;
         repeat_count_ff       <= `TPG_RST_REPEAT;
         period_ff             <= `TPG_RST_PERIOD;
         first_phase_length_ff <= `TPG_RST_PHASE;
      end else if (wr_commit) begin
         case (paddr)
            `TPG_OFF_CONFIG: begin
               mode_ff              <= pwdata[`TPG_CFG_MODE_MSB:`TPG_CFG_MODE_LSB];
               trig_sel_ff          <= pwdata[`TPG_CFG_TRIG_MSB:`TPG_CFG_TRIG_LSB];
               first_phase_level_ff <= pwdata[`TPG_CFG_P1LEV];
               idle_level_ff        <= pwdata[`TPG_CFG_IDLELEV];
               irq_enable_ff        <= pwdata[`TPG_CFG_IRQEN];
            end
            `TPG_OFF_REPEAT: repeat_count_ff       <= pwdata[RPT_W-1:0];
            `TPG_OFF_PERIOD: period_ff             <= pwdata[CNT_W-1:0];
            `TPG_OFF_PHASE:  first_phase_length_ff <= pwdata[CNT_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Two-stage synchroniser; edge logic compares the second stage with its one-clock delayed copy
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         vs_meta_ff <= 1'b0;
         vs_sync_ff <= 1'b0;
         vs_last_ff <= 1'b0;
      end else begin
         vs_meta_ff <= camera_vsync_in;
         vs_sync_ff <= vs_meta_ff;
         vs_last_ff <= vs_sync_ff;
      end
   end

   assign rise_seen = vs_sync_ff & ~vs_last_ff;
   assign fall_seen = ~vs_sync_ff & vs_last_ff;

   // Edge selection; the reserved code never fires
   always @* begin
      case (trig_sel_ff)
         `TPG_TRIG_RISE: trig_hit = rise_seen;
         `TPG_TRIG_FALL: trig_hit = fall_seen;
         default:        trig_hit = 1'b0;
      endcase
   end

   // Controller next-state logic
   always @* begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_per_sh = per_sh_ff;
      nxt_ph1_sh = ph1_sh_ff;
      nxt_rem    = rem_ff;
      nxt_wave   = idle_level_ff;
      nxt_event  = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            nxt_wave = idle_level_ff;
         end
         ST_ARMED: begin
            nxt_wave = idle_level_ff;
         end
         ST_RUN: begin
            nxt_wave = phase_level(cnt_ff, ph1_sh_ff, first_phase_level_ff);
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (mode_off) begin
         // Stop from any state; pin returns to idle level on the next edge
         nxt_state = ST_IDLE;
         nxt_wave  = idle_level_ff;
      end else if (wr_start) begin
         // Restart or arm with whatever is programmed right now
         nxt_rem = {1'b0, repeat_count_ff};
         if (trig_enabled) begin
            nxt_state = ST_ARMED;
            nxt_wave  = idle_level_ff;
         end else begin
            nxt_state  = ST_RUN;
            nxt_cnt    = {CNT_W{1'b0}};
            nxt_per_sh = period_ff;
            nxt_ph1_sh = first_phase_length_ff;
            nxt_wave   = phase_level({CNT_W{1'b0}}, first_phase_length_ff,
                                     first_phase_level_ff);
            nxt_event  = mode_cont;
         end
      end else if (state_ff == ST_ARMED) begin
         if (trig_hit) begin
            nxt_state  = ST_RUN;
            nxt_cnt    = {CNT_W{1'b0}};
            nxt_per_sh = period_ff;
            nxt_ph1_sh = first_phase_length_ff;
            nxt_wave   = phase_level({CNT_W{1'b0}}, first_phase_length_ff,
                                     first_phase_level_ff);
            nxt_event  = mode_cont;
         end
      end else if (state_ff == ST_RUN) begin
         // Edges are not looked at while running; only a new start re-arms
         if (leave_cont) begin
            // Graceful stop: current period plus repeat+1 further ones
            nxt_rem = {1'b0, repeat_count_ff} + {{RPT_W{1'b0}}, 1'b1};
         end
         if (period_end) begin
            // Period of per+1 clocks has ended
            if (mode_oneshot && nxt_rem == {(RPT_W+1){1'b0}}) begin
               nxt_state = ST_IDLE;
               nxt_wave  = idle_level_ff;
               nxt_event = 1'b1;
            end else begin
               if (mode_oneshot) begin
                  nxt_rem = nxt_rem - {{RPT_W{1'b0}}, 1'b1};
               end
               nxt_cnt    = {CNT_W{1'b0}};
               nxt_per_sh = period_ff;
               nxt_ph1_sh = first_phase_length_ff;
               nxt_wave   = phase_level({CNT_W{1'b0}}, first_phase_length_ff,
                                        first_phase_level_ff);
               nxt_event  = mode_cont;
            end
         end else begin
            nxt_cnt  = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            nxt_wave = phase_level(nxt_cnt, ph1_sh_ff, first_phase_level_ff);
         end
      end
   end

   // Controller registers and registered outputs
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         state_ff      <= ST_IDLE;
         cnt_ff        <= {CNT_W{1'b0}};
         per_sh_ff     <= {CNT_W{1'b0}};
         ph1_sh_ff     <= {CNT_W{1'b0}};
         rem_ff        <= {(RPT_W+1){1'b0}};
         mode_prev_ff  <= `TPG_MODE_OFF;
         waveform_out  <= 1'b0;
         irq_out       <= 1'b0;
         dma_event_out <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         cnt_ff        <= nxt_cnt;
         per_sh_ff     <= nxt_per_sh;
         ph1_sh_ff     <= nxt_ph1_sh;
         rem_ff        <= nxt_rem;
         mode_prev_ff  <= mode_ff;
         waveform_out  <= nxt_wave;
         irq_out       <= nxt_event & irq_enable_ff;
         dma_event_out <= nxt_event;
      end
   end

endmodule // tpg_top

// ---- tb/testbench.sv ----
// Self-checking bench for the two-phase pulse generator
`timescale 1ns/1ps
`include "tpg_defs.vh"
module testbench;
   logic        clock, reset, psel, penable, pwrite, camera_vsync_in, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   wire  [31:0] prdata;
   wire         pready, pslverr, waveform_out, irq_out, dma_event_out;
   int          n_errors = 0;
   int          checked = 0;
   int          cyc = 0;

   tpg_top dut_u (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .camera_vsync_in(camera_vsync_in), .waveform_out(waveform_out),
      .irq_out(irq_out), .dma_event_out(dma_event_out));

   // Cycle count for latency checks
   always @(posedge clock) cyc <= cyc + 1;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      check("pready", pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      check("prdata", rd, exp);
      check("pslverr", err, e);
   endtask

   // Sample a step after the edge so design updates have landed
   task automatic tick;
      @(posedge clock);
      #1;
   endtask

   task automatic wave(input logic p1, input int per, input int len, input int np, input logic c);
      int ph;
      for (int i = 0; i < np * (per + 1); i++) begin
         ph = i % (per + 1);
         check("pin", waveform_out, (ph < len) ? p1 : !p1);
         check("dma", dma_event_out, c && ph == 0);
         check("irq", irq_out, c && ph == 0);
         tick;
      end
   endtask

   task automatic quiet(input logic lvl, input int n);
      repeat (n) begin
         tick;
         check("idle pin", waveform_out, lvl);
         check("idle dma", dma_event_out, 1'b0);
      end
   endtask

   // Run end: pin idle on the same cycle as the event pulse
   task automatic ends(input logic idle, input logic irq);
      check("end pin", waveform_out, idle);
      check("end dma", dma_event_out, 1'b1);
      check("end irq", irq_out, irq);
   endtask

   task automatic wait_dma;
      int n;
      n = 0;
      while (dma_event_out !== 1'b1 && n < 60) begin
         tick;
         n++;
      end
   endtask

   task automatic t_regs;
      rchk(`TPG_OFF_PERIOD, 32'h0, 1'b0);
      wr(`TPG_OFF_PERIOD, 32'hFFFFFFFF);
      rchk(`TPG_OFF_PERIOD, 32'hFFFFFFFF, 1'b0);
      wr(`TPG_OFF_REPEAT, 32'h000001FF);
      rchk(`TPG_OFF_REPEAT, 32'h000000FF, 1'b0);
      wr(12'h004, 32'h1);
      check("wr err", err, 1'b1);
      rchk(12'h004, 32'h0, 1'b1);
      wr(`TPG_OFF_START, 32'h1);
      quiet(1'b0, 5);
      $display("registers done");
   endtask

   task automatic t_oneshot;
      wr(`TPG_OFF_PERIOD, 32'h3);
      wr(`TPG_OFF_PHASE, 32'h1);
      wr(`TPG_OFF_REPEAT, 32'h2);
      wr(`TPG_OFF_CONFIG, 32'h51);
      wr(`TPG_OFF_START, 32'h1);
      #1;
      wave(1'b1, 3, 1, 3, 1'b0);
      ends(1'b0, 1'b1);
      quiet(1'b0, 10);
      $display("one-shot done");
   endtask

   // Zero and oversize first phase, low first level, idle high, irq off
   task automatic t_edges;
      wr(`TPG_OFF_PERIOD, 32'h4);
      wr(`TPG_OFF_REPEAT, 32'h0);
      wr(`TPG_OFF_CONFIG, 32'h21);
      for (int k = 0; k < 2; k++) begin
         wr(`TPG_OFF_PHASE, k ? 32'h5 : 32'h0);
         wr(`TPG_OFF_START, 32'h1);
         #1;
         wave(1'b0, 4, k * 5, 1, 1'b0);
         ends(1'b1, 1'b0);
      end
      $display("phase limits done");
   endtask

   task automatic t_cont;
      int c0;
      wr(`TPG_OFF_PERIOD, 32'h7);
      wr(`TPG_OFF_PHASE, 32'h3);
      wr(`TPG_OFF_REPEAT, 32'h1);
      wr(`TPG_OFF_CONFIG, 32'h52);
      wr(`TPG_OFF_START, 32'h1);
      #1;
      wave(1'b1, 7, 3, 1, 1'b1);
      wr(`TPG_OFF_PERIOD, 32'h9);
      wait_dma;
      wave(1'b1, 9, 3, 1, 1'b1);
      c0 = cyc;
      wr(`TPG_OFF_CONFIG, 32'h51);
      wait_dma;
      check("stop delay", cyc - c0, 32'd30);
      ends(1'b0, 1'b1);
      $display("continuous done");
   endtask

   task automatic t_trig;
      int n;
      wr(`TPG_OFF_PERIOD, 32'h7);
      wr(`TPG_OFF_PHASE, 32'h2);
      wr(`TPG_OFF_REPEAT, 32'h0);
      for (int tr = 1; tr < 4; tr++) begin
         @(posedge clock);
         camera_vsync_in <= (tr == 2);
         wr(`TPG_OFF_CONFIG, 32'h51 | (tr << 2));
         wr(`TPG_OFF_START, 32'h1);
         if (tr < 3) begin
            quiet(1'b0, 8);
            @(posedge clock);
            camera_vsync_in <= (tr == 1);
            #1;
            n = 0;
            while (waveform_out !== 1'b1 && n < 8) begin
               tick;
               n++;
            end
            check("trig start", n < 8, 1'b1);
            fork
               wave(1'b1, 7, 2, 1, 1'b0);
               begin
                  repeat (2) @(posedge clock);
                  camera_vsync_in <= (tr == 2);
                  repeat (2) @(posedge clock);
                  camera_vsync_in <= (tr == 1);
               end
            join
            ends(1'b0, 1'b1);
         end else begin
            tick;
            check("reserved trig", waveform_out, 1'b1);
            wr(`TPG_OFF_CONFIG, 32'h0);
            tick;
            check("stop pin", waveform_out, 1'b0);
         end
         quiet(1'b0, 10);
      end
      $display("trigger done");
   endtask

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Watchdog, several times the expected run length
   initial begin
      repeat (5000) @(posedge clock);
      n_errors++;
      $display("timeout");
      stop_test;
   end

   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      camera_vsync_in = 1'b0;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      t_regs;
      t_oneshot;
      t_edges;
      t_cont;
      t_trig;
      stop_test;
   end
endmodule // testbench

// ---- tb/tpg_chk.sv ----
// Port checker for the two-phase pulse generator
`timescale 1ns/1ps
module tpg_chk (
   input logic        clock,
   input logic        reset,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic        pready,
   input logic        pslverr,
   input logic        waveform_out,
   input logic        irq_out,
   input logic        dma_event_out
);
   logic [6:0] cfg_ff;
   logic       mapped;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Config copy, taken on the same commit edge as the design
   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         cfg_ff <= 7'h00;
      else if (psel && penable && pready && pwrite && paddr == 12'h008)
         cfg_ff <= pwdata[6:0];
   end
   // Offset 4 stays unmapped on purpose
   assign mapped = paddr inside {12'h000, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
   a_irq_pulse: assert property (irq_out |=> !irq_out) else $error("irq too long");
   a_dma_pulse: assert property (dma_event_out |=> !dma_event_out) else $error("dma too long");
   a_irq_has_dma: assert property (irq_out |-> dma_event_out) else $error("irq without dma");
   a_irq_gate: assert property (dma_event_out |-> irq_out == $past(cfg_ff[6]))
      else $error("irq not gated by enable");
   a_idle_level: assert property (cfg_ff[1:0] == 2'h0 && $stable(cfg_ff)
      |-> waveform_out == cfg_ff[5]) else $error("pin not at idle level");
   a_off_quiet: assert property (cfg_ff[1:0] == 2'h0 && $stable(cfg_ff)
      |-> !dma_event_out) else $error("event while off");
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   a_err_unmapped: assert property (pready && !mapped |-> pslverr) else $error("no pslverr");
   a_err_mapped: assert property (pready && mapped |-> !pslverr) else $error("bad pslverr");
   c_irq: cover property (irq_out);
   c_err: cover property (pready && pslverr);
   c_rise: cover property ($rose(waveform_out));
endmodule // tpg_chk

bind tpg_top tpg_chk chk_u (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .waveform_out(waveform_out), .irq_out(irq_out), .dma_event_out(dma_event_out));
